/* osrp_consts.svh */
// offsets, field positions, reset values and timing counts for the origin profile block
`ifndef OSRP_CONSTS_SVH
`define OSRP_CONSTS_SVH

`define OSRP_ADDR_W 8
`define OSRP_OFF_CTRL 8'h00
`define OSRP_OFF_CMD 8'h04
`define OSRP_OFF_S_ACC 8'h08
`define OSRP_OFF_S_DEC 8'h0C
`define OSRP_OFF_S_SPD 8'h10
`define OSRP_OFF_R_SPD 8'h14
`define OSRP_OFF_R_ACC 8'h18
`define OSRP_OFF_R_DEC 8'h1C
`define OSRP_OFF_MON 8'h20
`define OSRP_OFF_STATUS 8'h24
`define OSRP_OFF_FREQ 8'h28
`define OSRP_OFF_IRQ_STAT 8'h2C
`define OSRP_OFF_IRQ_MASK 8'h30

`define OSRP_CTRL_SEARCH_EN 0
`define OSRP_CTRL_MODE_LO 1
`define OSRP_CMD_SEARCH 0
`define OSRP_CMD_RETURN 1
`define OSRP_CMD_DECEL 2
`define OSRP_IRQ_DONE 0
`define OSRP_IRQ_ERR 1

`define OSRP_MODE_INP 2'h2
`define OSRP_ERR_TIMEOUT 16'h0300
`define OSRP_ERR_NONE 16'h0000
`define OSRP_RATE_RST 16'h0000
`define OSRP_SPEED_RST 17'h00000
`define OSRP_MON_RST 14'h0000
`define OSRP_MON_MAX 14'h270F

`define OSRP_CLK_HZ 26'h17D7840
`define OSRP_CLK_PERIOD_NS 40
`define OSRP_MS_NS 1000000
`define OSRP_STEP_MS 4
`define OSRP_MS_CYCLES (`OSRP_MS_NS / `OSRP_CLK_PERIOD_NS)

`endif

/* osrp_pkg.sv */
// types shared by the origin profile block
package osrp_pkg;
   typedef enum logic [1:0] {
      OSRP_IDLE = 2'b00,
      OSRP_ACCEL = 2'b01,
      OSRP_DECEL = 2'b10,
      OSRP_WAIT = 2'b11
   } osrp_state_t;

   typedef enum logic {
      OSRP_OP_RETURN = 1'b0,
      OSRP_OP_SEARCH = 1'b1
   } osrp_op_t;
endpackage

/* osrp_tick_if.sv */
// millisecond and ramp step ticks between the profile and its timebase
interface osrp_tick_if;
   logic restart;
   logic ms_tick;
   logic step_tick;
   modport gen (input restart, output ms_tick, output step_tick);
   modport use_side (output restart, input ms_tick, input step_tick);
endinterface

/* osrp_tick.sv */
// timebase: one pulse per millisecond and one per ramp step
`include "osrp_consts.svh"
module osrp_tick #(
   parameter int MS_CYCLES = `OSRP_MS_CYCLES,
   parameter int STEP_MS = `OSRP_STEP_MS
) (
   input wire logic clk,
   input wire logic resetn,
   osrp_tick_if.gen tb
);
   logic [31:0] cyc_reg;
   logic [7:0] ms_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cyc_reg <= 32'h00000000;
         tb.ms_tick <= 1'b0;
      end else if (tb.restart || cyc_reg == 32'(MS_CYCLES - 1)) begin
         cyc_reg <= 32'h00000000;
         tb.ms_tick <= !tb.restart;
      end else begin
         cyc_reg <= cyc_reg + 32'h00000001;
         tb.ms_tick <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ms_reg <= 8'h00;
         tb.step_tick <= 1'b0;
      end else if (tb.restart) begin
         ms_reg <= 8'h00;
         tb.step_tick <= 1'b0;
      end else if (tb.ms_tick) begin
         ms_reg <= (ms_reg == 8'(STEP_MS - 1)) ? 8'h00 : ms_reg + 8'h01;
         tb.step_tick <= (ms_reg == 8'(STEP_MS - 1));
      end else begin
         tb.step_tick <= 1'b0;
      end
   end
endmodule

/* osrp_profile.sv */
// origin search and origin return speed profile with in-position watchdog
// What this block does
// - search: add acceleration rate every 4 ms
// - search: subtract deceleration rate every 4 ms
// - return: add acceleration step every 4 ms
// - return: subtract deceleration step every 4 ms
// - return runs at configured target speed
// - in-position timeout gives code 0300, stop flag
// - timeout only with search enabled, mode 2
// - search rates used only when search enabled
// - parameters latched at start, later writes wait
// - mode 2 drive answers in-position after output
//
// The implementer's own choices: the placing of the registers and strobed register access.
`include "osrp_consts.svh"
module osrp_profile #(
   parameter int MS_CYCLES = `OSRP_MS_CYCLES,
   parameter int STEP_MS = `OSRP_STEP_MS
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic in_position_signal,
   input wire logic decel_req,
   output logic pulse_out,
   output logic busy,
   output logic stopped_error,
   output logic irq
);
   if (MS_CYCLES < 1 || STEP_MS < 1 || STEP_MS > 255) begin : g_bad
      $error("osrp_profile: tick parameters out of range");
   end

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   osrp_tick_if tb ();
   osrp_tick #(.MS_CYCLES(MS_CYCLES), .STEP_MS(STEP_MS)) u_tick (
      .clk(clk),
      .resetn(resetn),
      .tb(tb.gen)
   );

   ////////////////////////////////////////////////////////////////////////////
   // software settings
   logic search_en_reg;
   logic [1:0] mode_reg;
   logic [15:0] s_acc_reg, s_dec_reg, r_acc_reg, r_dec_reg;
   logic [16:0] s_spd_reg, r_spd_reg;
   logic [13:0] mon_reg;
   logic [1:0] irq_mask_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         search_en_reg <= 1'b0;
         mode_reg <= 2'h0;
         s_acc_reg <= `OSRP_RATE_RST;
         s_dec_reg <= `OSRP_RATE_RST;
         r_acc_reg <= `OSRP_RATE_RST;
         r_dec_reg <= `OSRP_RATE_RST;
         s_spd_reg <= `OSRP_SPEED_RST;
         r_spd_reg <= `OSRP_SPEED_RST;
         mon_reg <= `OSRP_MON_RST;
         irq_mask_reg <= 2'h0;
      end else if (wr) begin
         if (hit(addr, `OSRP_OFF_CTRL)) begin
            search_en_reg <= wdata[`OSRP_CTRL_SEARCH_EN];
            mode_reg <= wdata[`OSRP_CTRL_MODE_LO +: 2];
         end
         if (hit(addr, `OSRP_OFF_S_ACC)) s_acc_reg <= wdata[15:0];
         if (hit(addr, `OSRP_OFF_S_DEC)) s_dec_reg <= wdata[15:0];
         if (hit(addr, `OSRP_OFF_R_ACC)) r_acc_reg <= wdata[15:0];
         if (hit(addr, `OSRP_OFF_R_DEC)) r_dec_reg <= wdata[15:0];
         if (hit(addr, `OSRP_OFF_S_SPD)) s_spd_reg <= wdata[16:0];
         if (hit(addr, `OSRP_OFF_R_SPD)) r_spd_reg <= wdata[16:0];
         if (hit(addr, `OSRP_OFF_MON)) begin
            // compare the whole word so that large values clamp instead of wrapping
            mon_reg <= (wdata > {18'h00000, `OSRP_MON_MAX}) ? `OSRP_MON_MAX : wdata[13:0];
         end
         if (hit(addr, `OSRP_OFF_IRQ_MASK)) irq_mask_reg <= wdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // start decoding and parameter latch
   osrp_pkg::osrp_state_t state_reg;
   logic cmd_wr, go_search, go_return, go;
   assign cmd_wr = wr && hit(addr, `OSRP_OFF_CMD) && state_reg == osrp_pkg::OSRP_IDLE;
   assign go_search = cmd_wr && wdata[`OSRP_CMD_SEARCH] && !wdata[`OSRP_CMD_RETURN]
                      && search_en_reg;
   assign go_return = cmd_wr && wdata[`OSRP_CMD_RETURN] && !wdata[`OSRP_CMD_SEARCH];
   assign go = go_search || go_return;

   logic [15:0] acc_lat, dec_lat;
   logic [16:0] tgt_lat;
   logic [13:0] mon_lat;
   osrp_pkg::osrp_op_t op_lat;
   logic inp_mode_lat;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         acc_lat <= `OSRP_RATE_RST;
         dec_lat <= `OSRP_RATE_RST;
         tgt_lat <= `OSRP_SPEED_RST;
         mon_lat <= `OSRP_MON_RST;
         op_lat <= osrp_pkg::OSRP_OP_RETURN;
         inp_mode_lat <= 1'b0;
      end else if (go) begin
         acc_lat <= go_search ? s_acc_reg : r_acc_reg;
         dec_lat <= go_search ? s_dec_reg : r_dec_reg;
         tgt_lat <= go_search ? s_spd_reg : r_spd_reg;
         mon_lat <= mon_reg;
         op_lat <= go_search ? osrp_pkg::OSRP_OP_SEARCH : osrp_pkg::OSRP_OP_RETURN;
         inp_mode_lat <= go_search && search_en_reg && mode_reg == `OSRP_MODE_INP;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ramp state machine
   logic [16:0] freq_reg;
   logic [17:0] up_sum;
   logic [13:0] ms_cnt_reg;
   logic stop_cmd, out_done, wait_ok, wait_err;
   assign up_sum = {1'b0, freq_reg} + {2'b00, acc_lat};
   assign stop_cmd = decel_req || (wr && hit(addr, `OSRP_OFF_CMD) && wdata[`OSRP_CMD_DECEL]);
   assign out_done = state_reg == osrp_pkg::OSRP_DECEL && tb.step_tick
                     && freq_reg <= {1'b0, dec_lat};
   assign wait_ok = state_reg == osrp_pkg::OSRP_WAIT && in_position_signal;
   assign wait_err = state_reg == osrp_pkg::OSRP_WAIT && !in_position_signal
                     && ms_cnt_reg >= mon_lat;
   assign tb.restart = go || (out_done && inp_mode_lat);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= osrp_pkg::OSRP_IDLE;
         freq_reg <= `OSRP_SPEED_RST;
      end else begin
         unique case (state_reg)
            osrp_pkg::OSRP_IDLE: begin
               freq_reg <= `OSRP_SPEED_RST;
               if (go) state_reg <= osrp_pkg::OSRP_ACCEL;
            end
            osrp_pkg::OSRP_ACCEL: begin
               if (stop_cmd || tgt_lat == `OSRP_SPEED_RST) begin
                  state_reg <= osrp_pkg::OSRP_DECEL;
               end else if (tb.step_tick) begin
                  freq_reg <= (up_sum >= {1'b0, tgt_lat}) ? tgt_lat : up_sum[16:0];
               end
            end
            osrp_pkg::OSRP_DECEL: begin
               if (out_done) begin
                  freq_reg <= `OSRP_SPEED_RST;
                  state_reg <= inp_mode_lat ? osrp_pkg::OSRP_WAIT : osrp_pkg::OSRP_IDLE;
               end else if (tb.step_tick) begin
                  freq_reg <= freq_reg - {1'b0, dec_lat};
               end
            end
            osrp_pkg::OSRP_WAIT: begin
               if (wait_ok || wait_err) state_reg <= osrp_pkg::OSRP_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) ms_cnt_reg <= 14'h0000;
      else if (state_reg != osrp_pkg::OSRP_WAIT) ms_cnt_reg <= 14'h0000;
      else if (tb.ms_tick && ms_cnt_reg != 14'h3FFF) ms_cnt_reg <= ms_cnt_reg + 14'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pulse train: phase accumulator, one-cycle pulse per output pulse
   logic [25:0] phase_reg;
   logic [26:0] phase_sum;
   logic running;
   assign running = state_reg == osrp_pkg::OSRP_ACCEL || state_reg == osrp_pkg::OSRP_DECEL;
   assign phase_sum = {1'b0, phase_reg} + {10'h000, freq_reg};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         phase_reg <= 26'h0000000;
         pulse_out <= 1'b0;
      end else if (!running) begin
         phase_reg <= 26'h0000000;
         pulse_out <= 1'b0;
      end else if (phase_sum >= {1'b0, `OSRP_CLK_HZ}) begin
         phase_reg <= 26'(phase_sum - {1'b0, `OSRP_CLK_HZ});
         pulse_out <= 1'b1;
      end else begin
         phase_reg <= phase_sum[25:0];
         pulse_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // error flag, events, interrupt, readback
   logic [15:0] err_code_reg;
   logic [1:0] irq_stat_reg, irq_ev;
   logic done_ev;
   assign done_ev = wait_ok || (out_done && !inp_mode_lat);
   assign irq_ev = {wait_err, done_ev};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stopped_error <= 1'b0;
         err_code_reg <= `OSRP_ERR_NONE;
      end else if (wait_err) begin
         stopped_error <= 1'b1;
         err_code_reg <= `OSRP_ERR_TIMEOUT;
      end else if (go) begin
         stopped_error <= 1'b0;
         err_code_reg <= `OSRP_ERR_NONE;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_stat_reg <= 2'h0;
         irq <= 1'b0;
         busy <= 1'b0;
      end else begin
         irq_stat_reg <= ((rd && hit(addr, `OSRP_OFF_IRQ_STAT)) ? 2'h0 : irq_stat_reg) | irq_ev;
         irq <= |(irq_stat_reg & irq_mask_reg);
         busy <= go || (state_reg != osrp_pkg::OSRP_IDLE && !wait_ok && !wait_err
                 && !(out_done && !inp_mode_lat));
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) rdata <= 32'h00000000;
      else if (!rd) rdata <= 32'h00000000;
      else begin
         unique case (addr)
            `OSRP_OFF_CTRL: rdata <= {29'h0, mode_reg, search_en_reg};
            `OSRP_OFF_S_ACC: rdata <= {16'h0000, s_acc_reg};
            `OSRP_OFF_S_DEC: rdata <= {16'h0000, s_dec_reg};
            `OSRP_OFF_S_SPD: rdata <= {15'h0000, s_spd_reg};
            `OSRP_OFF_R_SPD: rdata <= {15'h0000, r_spd_reg};
            `OSRP_OFF_R_ACC: rdata <= {16'h0000, r_acc_reg};
            `OSRP_OFF_R_DEC: rdata <= {16'h0000, r_dec_reg};
            `OSRP_OFF_MON: rdata <= {18'h00000, mon_reg};
            `OSRP_OFF_STATUS: rdata <= {err_code_reg, 12'h000, stopped_error, state_reg, busy};
            `OSRP_OFF_FREQ: rdata <= {15'h0000, freq_reg};
            `OSRP_OFF_IRQ_STAT: rdata <= {30'h0, irq_stat_reg};
            `OSRP_OFF_IRQ_MASK: rdata <= {30'h0, irq_mask_reg};
            default: rdata <= 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   accel_step_a: assert property (@(posedge clk) disable iff (!resetn)
      state_reg == osrp_pkg::OSRP_ACCEL && !stop_cmd && tgt_lat != 17'h0 && tb.step_tick
      && up_sum < {1'b0, tgt_lat} |=> freq_reg == $past(freq_reg) + {1'b0, $past(acc_lat)})
      else $error("ramp up step wrong");
   decel_step_a: assert property (@(posedge clk) disable iff (!resetn)
      state_reg == osrp_pkg::OSRP_DECEL && tb.step_tick && freq_reg > {1'b0, dec_lat}
      |=> freq_reg == $past(freq_reg) - {1'b0, $past(dec_lat)})
      else $error("ramp down step wrong");
   freq_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      state_reg != osrp_pkg::OSRP_IDLE && !tb.step_tick && !out_done |=> $stable(freq_reg))
      else $error("speed changed between steps");
   target_cap_a: assert property (@(posedge clk) disable iff (!resetn)
      freq_reg <= tgt_lat)
      else $error("speed above target");
   timeout_err_a: assert property (@(posedge clk) disable iff (!resetn)
      wait_err |=> stopped_error && err_code_reg == 16'h0300 && state_reg == osrp_pkg::OSRP_IDLE
      ##1 irq_stat_reg[`OSRP_IRQ_ERR])
      else $error("timeout not reported");
   inp_gate_a: assert property (@(posedge clk) disable iff (!resetn)
      state_reg != osrp_pkg::OSRP_WAIT ##1 state_reg == osrp_pkg::OSRP_WAIT
      |-> op_lat == osrp_pkg::OSRP_OP_SEARCH && inp_mode_lat)
      else $error("watchdog entered outside mode 2 search");
   search_refuse_a: assert property (@(posedge clk) disable iff (!resetn)
      cmd_wr && wdata[`OSRP_CMD_SEARCH] && !search_en_reg |=> state_reg == osrp_pkg::OSRP_IDLE)
      else $error("search started while disabled");
   param_latch_a: assert property (@(posedge clk) disable iff (!resetn)
      state_reg != osrp_pkg::OSRP_IDLE ##1 state_reg != osrp_pkg::OSRP_IDLE
      |-> $stable(acc_lat) && $stable(dec_lat) && $stable(tgt_lat) && $stable(mon_lat))
      else $error("parameters changed while running");
   inp_done_a: assert property (@(posedge clk) disable iff (!resetn)
      wait_ok |=> state_reg == osrp_pkg::OSRP_IDLE && !stopped_error && !busy)
      else $error("in-position not accepted");
endmodule

/* osrp_drive_model.sv */
// servo drive model that reports in-position once the pulse train has gone quiet
module osrp_drive_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic pulse_out,
   input wire logic respond,
   input wire logic [7:0] settle,
   output logic in_position_signal
);
   logic [7:0] quiet_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // settling time since the last pulse received
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         quiet_reg <= 8'h00;
      end else if (pulse_out || !respond) begin
         quiet_reg <= 8'h00;
      end else if (quiet_reg != 8'hFF) begin
         quiet_reg <= quiet_reg + 8'h01;
      end
   end

   // completion only after the shaft has settled; a silent drive never answers
   assign in_position_signal = respond && (quiet_reg >= settle);
endmodule

/* origin_search_return_profile_tb_top.sv */
// self-checking bench for the origin search and return profile
`include "osrp_consts.svh"
module origin_search_return_profile_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MSC = 10;
   localparam int STEP = MSC * `OSRP_STEP_MS;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0, rd = 1'b0, decel_req = 1'b0, respond = 1'b0;
   logic [7:0] settle = 8'h0A;
   logic [31:0] rdata;
   logic in_position_signal, pulse_out, busy, stopped_error, irq;
   logic [1:0] mask;
   logic [31:0] d;
   int cyc = 0;
   int fail_count = 0;
   int check_count = 0;

   always #20 clk = ~clk;
   always @(negedge clk) cyc++;

   osrp_profile #(.MS_CYCLES(MSC), .STEP_MS(`OSRP_STEP_MS)) dut (.clk(clk), .resetn(resetn),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .in_position_signal(in_position_signal), .decel_req(decel_req), .pulse_out(pulse_out),
      .busy(busy), .stopped_error(stopped_error), .irq(irq));
   osrp_drive_model drive (.clk(clk), .resetn(resetn), .pulse_out(pulse_out),
      .respond(respond), .settle(settle), .in_position_signal(in_position_signal));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic cmp_val(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cmp_bit(input string n, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic wait_to(input int t);
      while (cyc < t) @(posedge clk);
   endtask

   function automatic int ramp_up(input int f, input int acc, input int tgt);
      return (f + acc > tgt) ? tgt : f + acc;
   endfunction

   function automatic int ramp_dn(input int f, input int dec);
      return (f <= dec) ? 0 : f - dec;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // kind: 0 no watchdog, 1 drive answers, 2 drive silent
   task automatic run(input bit srch, input int kind);
      int acc, dec, tgt, f, k, tz;
      logic [7:0] ra;
      acc = 1000 + $urandom % 3000;
      dec = 1000 + $urandom % 3000;
      tgt = 3 * acc + 1 + $urandom % (acc - 1);
      ra = srch ? `OSRP_OFF_S_ACC : `OSRP_OFF_R_ACC;
      bus_wr(ra, 32'(acc));
      bus_wr(ra + 8'h04, 32'(dec));
      bus_wr(srch ? `OSRP_OFF_S_SPD : `OSRP_OFF_R_SPD, 32'(tgt));
      respond <= 1'b0;
      bus_wr(`OSRP_OFF_CMD, srch ? 32'h1 : 32'h2);
      tz = cyc;
      f = 0;
      for (k = 1; k < 6; k++) begin
         wait_to(tz + 20 + STEP * k);
         f = ramp_up(f, acc, tgt);
         bus_rd(`OSRP_OFF_FREQ, d);
         cmp_val("freq_up", 32'(f), d);
         if (k == 1) cmp_bit("err_clear", 1'b0, stopped_error);
         if (k == 2) bus_wr(ra, 32'(acc + 500));
      end
      @(posedge clk);
      decel_req <= 1'b1;
      k = 5;
      while (f != 0) begin
         k++;
         wait_to(tz + 20 + STEP * k);
         f = ramp_dn(f, dec);
         bus_rd(`OSRP_OFF_FREQ, d);
         cmp_val("freq_down", 32'(f), d);
      end
      @(posedge clk);
      decel_req <= 1'b0;
      tz = cyc;
      if (kind == 1) respond <= 1'b1;
      wait_to(tz + 5);
      cmp_bit("busy_wait", kind != 0, busy);
      wait_to(tz + 15);
      cmp_bit("stop_err_early", 1'b0, stopped_error);
      wait_to(tz + 45);
      cmp_bit("busy_end", 1'b0, busy);
      cmp_bit("stop_err", kind == 2, stopped_error);
      cmp_bit("pulse_idle", 1'b0, pulse_out);
      bus_rd(`OSRP_OFF_STATUS, d);
      if (kind == 2) cmp_val("err_code", 32'h0300, {16'h0, d[31:16]});
      else cmp_val("err_code", 32'h0, {16'h0, d[31:16]});
      cmp_bit("irq_level", kind == 2 ? mask[1] : mask[0], irq);
      bus_rd(`OSRP_OFF_IRQ_STAT, d);
      cmp_val("irq_stat", kind == 2 ? 32'h2 : 32'h1, d);
      repeat (3) @(posedge clk);
      cmp_bit("irq_clear", 1'b0, irq);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hB0E4));
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      for (int a = 0; a <= 'h34; a += 4) begin
         if (a != 4) begin
            bus_rd(8'(a), d);
            cmp_val("reset_val", 32'h0, d);
         end
      end
      bus_wr(`OSRP_OFF_MON, 32'h4E20);
      bus_rd(`OSRP_OFF_MON, d);
      cmp_val("mon_clamp", 32'h270F, d);
      bus_wr(`OSRP_OFF_MON, 32'h5);
      mask = 2'b11;
      bus_wr(`OSRP_OFF_IRQ_MASK, {30'h0, mask});
      $display("test reset values done");
      run(1'b0, 0);
      $display("test return ramp done");
      bus_wr(`OSRP_OFF_CTRL, 32'h1);
      run(1'b1, 0);
      $display("test search mode 0 done");
      bus_wr(`OSRP_OFF_CTRL, 32'h0);
      bus_wr(`OSRP_OFF_CMD, 32'h1);
      repeat (5) @(posedge clk);
      cmp_bit("search_disabled", 1'b0, busy);
      $display("test search disabled done");
      bus_wr(`OSRP_OFF_CTRL, 32'h5);
      run(1'b1, 1);
      $display("test in-position answer done");
      mask = 2'b01;
      bus_wr(`OSRP_OFF_IRQ_MASK, {30'h0, mask});
      run(1'b1, 2);
      $display("test watchdog timeout done");
      mask = 2'b11;
      bus_wr(`OSRP_OFF_IRQ_MASK, {30'h0, mask});
      run(1'b0, 0);
      $display("test return mode 2 done");
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      $display("[ERR] watchdog expected finish seen hang");
      end_sim();
   end
endmodule
